// ==== hdl/mwp_pin_sync.sv ====
`timescale 1ns/100ps
// three-stage input synchroniser; a change counts once stages 2 and 3 agree
module mwp_pin_sync
   import mwp_pkg::*;
#(
   parameter int unsigned W = 6
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         sys_rst_i,
   // raw pin level and settled level
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o
);

   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;
   logic [W-1:0] next_level;

   // accept a bit only when the two later stages agree
   always_comb begin
      for (int i = 0; i < W; i++) begin
         next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level_o[i];
      end
   end

   // stage1 feeds stage2 alone, keeping metastability off the logic
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         stage1  <= '0;
         stage2  <= '0;
         stage3  <= '0;
         level_o <= '0;
      end else begin
         stage1  <= pin_i;
         stage2  <= stage1;
         stage3  <= stage2;
         level_o <= next_level;
      end
   end

endmodule // mwp_pin_sync

// ==== hdl/mwp_top.sv ====
`timescale 1ns/100ps
// Function
// - one or two windows, size off/8K/16K/32K
// - bank lines pick bank, cpu lines pick byte
// - per-pin setting: bank line or general I/O
// - low three bank lines replace address 15..13
// - window size sets lowest bank line used
// - base is size multiple, 32K also 4000h
// - 32K at 0000h/8000h uses address 14..0
// - 32K at 4000h drives inverted bit 14
// - overlap goes to window 1
// - stored bank bits drive assigned lines on hit
// - size field 00 off, 01/10/11 sizes
// - base field gives top three bits
// - internal regions identical in every bank
module mwp_top
   import mwp_pkg::*;
(
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               sys_rst_i,
   // ahb-lite slave
   input  wire logic               hsel_i,
   input  wire logic [BUS_AW-1:0]  haddr_i,
   input  wire logic [1:0]         htrans_i,
   input  wire logic               hwrite_i,
   input  wire logic [2:0]         hsize_i,
   input  wire logic [BUS_DW-1:0]  hwdata_i,
   input  wire logic               hready_i,
   output logic                    hreadyout_o,
   output logic                    hresp_o,
   output logic [BUS_DW-1:0]       hrdata_o,
   // cpu address side
   input  wire logic [CPU_AW-1:0]  cpu_addr_i,
   input  wire logic               internal_sel_i,
   output logic [2:0]              addr_hi_o,
   // shared port pins
   input  wire logic [XA_W-1:0]    port_in_i,
   output logic [XA_W-1:0]         port_out_o,
   output logic [XA_W-1:0]         port_oe_o
);

   // software registers
   logic [XA_W-1:0] pin_assignment_setting;
   logic [1:0]      window_size_field1;
   logic [1:0]      window_size_field2;
   logic [2:0]      window_base_field1;
   logic [2:0]      window_base_field2;
   logic [XA_W-1:0] window_bank_select1;
   logic [XA_W-1:0] window_bank_select2;
   logic [XA_W-1:0] gpio_out;
   logic [XA_W-1:0] gpio_dir;
   logic [XA_W-1:0] next_pin_assignment_setting;
   logic [1:0]      next_window_size_field1;
   logic [1:0]      next_window_size_field2;
   logic [2:0]      next_window_base_field1;
   logic [2:0]      next_window_base_field2;
   logic [XA_W-1:0] next_window_bank_select1;
   logic [XA_W-1:0] next_window_bank_select2;
   logic [XA_W-1:0] next_gpio_out;
   logic [XA_W-1:0] next_gpio_dir;

   // bus data-phase state
   logic            wr_pend;
   logic [7:0]      wr_ofs;
   logic            next_wr_pend;
   logic [7:0]      next_wr_ofs;
   logic [BUS_DW-1:0] next_hrdata;
   logic            addr_take;

   // paging state
   logic            hit1_raw;
   logic            hit2_raw;
   logic            inv1;
   logic            inv2;
   logic [XA_W-1:0] use1;
   logic [XA_W-1:0] use2;
   logic            sel1;
   logic            sel2;
   logic [XA_W-1:0] next_xa;
   logic [XA_W-1:0] bank_address_lines;
   logic [2:0]      next_addr_hi;
   logic [XA_W-1:0] next_port_out;
   logic [XA_W-1:0] next_port_oe;
   logic            st_hit1;
   logic            st_hit2;
   logic [XA_W-1:0] gpio_level;

   // pick the bank line for one bit position of the active window
   function automatic logic xa_bit(
      input int unsigned     idx,
      input logic [XA_W-1:0] use_mask,
      input logic [XA_W-1:0] bank,
      input logic            inv14,
      input logic [2:0]      cpu_top
   );
      logic r;
      r = 1'b0;
      if (use_mask[idx]) begin
         r = bank[idx];
      end else if (idx == 1 && inv14) begin
         r = ~cpu_top[1];
      end else if (idx < 3) begin
         r = cpu_top[idx];
      end
      return r;
   endfunction

   // field write helper: shift the data down by pos and keep the low XA_W bits
   function automatic logic [XA_W-1:0] field6(
      input logic [BUS_DW-1:0] data,
      input int unsigned       pos
   );
      return XA_W'(data >> pos);
   endfunction

   // window decoders
   mwp_win_decode u_win1 (
      .cpu_top_i  (cpu_addr_i[15:13]),
      .size_i     (window_size_field1),
      .base_i     (window_base_field1),
      .hit_o      (hit1_raw),
      .bank_use_o (use1),
      .inv14_o    (inv1)
   );

   mwp_win_decode u_win2 (
      .cpu_top_i  (cpu_addr_i[15:13]),
      .size_i     (window_size_field2),
      .base_i     (window_base_field2),
      .hit_o      (hit2_raw),
      .bank_use_o (use2),
      .inv14_o    (inv2)
   );

   // general-purpose inputs come from pins, so they are synchronised
   mwp_pin_sync #(
      .W (XA_W)
   ) u_gpio_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     (port_in_i),
      .level_o   (gpio_level)
   );

   // bus address phase is taken only when the previous transfer is done
   assign addr_take = hsel_i & htrans_i[HTRANS_ACT_BIT] & hready_i;

   // register writes land in the data phase, one cycle after the address
   always_comb begin
      next_pin_assignment_setting = pin_assignment_setting;
      next_window_size_field1     = window_size_field1;
      next_window_size_field2     = window_size_field2;
      next_window_base_field1     = window_base_field1;
      next_window_base_field2     = window_base_field2;
      next_window_bank_select1    = window_bank_select1;
      next_window_bank_select2    = window_bank_select2;
      next_gpio_out               = gpio_out;
      next_gpio_dir               = gpio_dir;
      if (wr_pend) begin
         case (wr_ofs)
            OFS_PIN_ASSIGN: next_pin_assignment_setting =
               field6(hwdata_i, 0);
            OFS_WIN_SIZE: begin
               next_window_size_field1 = hwdata_i[POS_SIZE1 +: 2];
               next_window_size_field2 = hwdata_i[POS_SIZE2 +: 2];
            end
            OFS_WIN_BASE: begin
               next_window_base_field1 = hwdata_i[POS_BASE1 +: 3];
               next_window_base_field2 = hwdata_i[POS_BASE2 +: 3];
            end
            OFS_BANK_SEL1: next_window_bank_select1 =
               field6(hwdata_i, POS_BANK);
            OFS_BANK_SEL2: next_window_bank_select2 =
               field6(hwdata_i, POS_BANK);
            OFS_GPIO_OUT:  next_gpio_out = field6(hwdata_i, 0);
            OFS_GPIO_DIR:  next_gpio_dir = field6(hwdata_i, 0);
            default: begin
               // unmapped or read-only offsets ignore writes
               next_gpio_out = gpio_out;
            end
         endcase
      end
   end

   // read data is built from next values so a read right after a write
   // sees the new contents without a wait state
   always_comb begin
      next_wr_pend = addr_take & hwrite_i;
      next_wr_ofs  = {haddr_i[7:2], 2'h0};
      next_hrdata  = '0;
      if (addr_take && !hwrite_i) begin
         case ({haddr_i[7:2], 2'h0})
            OFS_PIN_ASSIGN: next_hrdata[XA_W-1:0] =
               next_pin_assignment_setting;
            OFS_WIN_SIZE: begin
               next_hrdata[POS_SIZE1 +: 2] = next_window_size_field1;
               next_hrdata[POS_SIZE2 +: 2] = next_window_size_field2;
            end
            OFS_WIN_BASE: begin
               next_hrdata[POS_BASE1 +: 3] = next_window_base_field1;
               next_hrdata[POS_BASE2 +: 3] = next_window_base_field2;
            end
            OFS_BANK_SEL1: next_hrdata[POS_BANK +: XA_W] =
               next_window_bank_select1;
            OFS_BANK_SEL2: next_hrdata[POS_BANK +: XA_W] =
               next_window_bank_select2;
            OFS_GPIO_OUT: next_hrdata[XA_W-1:0] = next_gpio_out;
            OFS_GPIO_DIR: next_hrdata[XA_W-1:0] = next_gpio_dir;
            OFS_GPIO_IN:  next_hrdata[XA_W-1:0] = gpio_level;
            OFS_STATUS: begin
               next_hrdata[POS_ST_HIT1]          = st_hit1;
               next_hrdata[POS_ST_HIT2]          = st_hit2;
               next_hrdata[POS_ST_XA +: XA_W]    = bank_address_lines;
            end
            default: next_hrdata = '0;   // unmapped reads as zero
         endcase
      end
   end

   // window selection and bank line composition
   always_comb begin
      // internal regions bypass paging so they look alike in every bank
      sel1 = hit1_raw & ~internal_sel_i;
      // window 1 wins where both match
      sel2 = hit2_raw & ~hit1_raw & ~internal_sel_i;
      for (int i = 0; i < XA_W; i++) begin
         if (sel1) begin
            next_xa[i] = xa_bit(i, use1, window_bank_select1,
                                inv1, cpu_addr_i[15:13]);
         end else if (sel2) begin
            next_xa[i] = xa_bit(i, use2, window_bank_select2,
                                inv2, cpu_addr_i[15:13]);
         end else begin
            // miss: low lines follow the address, high lines stay low
            next_xa[i] = xa_bit(i, '0, '0, 1'b0, cpu_addr_i[15:13]);
         end
      end
   end

   // address and pin outputs; all leave from flip-flops
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         // assigned low bank lines stand in for the cpu address
         next_addr_hi[i] = pin_assignment_setting[i] ?
                           next_xa[i] : cpu_addr_i[XA_LSB + i];
      end
      for (int i = 0; i < XA_W; i++) begin
         if (pin_assignment_setting[i]) begin
            next_port_out[i] = next_xa[i];
            next_port_oe[i]  = 1'b1;
         end else begin
            next_port_out[i] = gpio_out[i];
            next_port_oe[i]  = gpio_dir[i];
         end
      end
   end

   // one register stage for every piece of state; the paging outputs
   // lag the cpu address by one clock, traded for glitch-free pins
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pin_assignment_setting <= RST_PIN_ASSIGN;
         window_size_field1     <= RST_WIN_SIZE;
         window_size_field2     <= RST_WIN_SIZE;
         window_base_field1     <= RST_WIN_BASE;
         window_base_field2     <= RST_WIN_BASE;
         window_bank_select1    <= RST_BANK_SEL;
         window_bank_select2    <= RST_BANK_SEL;
         gpio_out               <= RST_GPIO;
         gpio_dir               <= RST_GPIO;
         wr_pend                <= 1'b0;
         wr_ofs                 <= 8'h00;
         hreadyout_o            <= 1'b1;
         hresp_o                <= 1'b0;
         hrdata_o               <= '0;
         bank_address_lines     <= '0;
         addr_hi_o              <= 3'h0;
         port_out_o             <= '0;
         port_oe_o              <= '0;
         st_hit1                <= 1'b0;
         st_hit2                <= 1'b0;
      end else begin
         pin_assignment_setting <= next_pin_assignment_setting;
         window_size_field1     <= next_window_size_field1;
         window_size_field2     <= next_window_size_field2;
         window_base_field1     <= next_window_base_field1;
         window_base_field2     <= next_window_base_field2;
         window_bank_select1    <= next_window_bank_select1;
         window_bank_select2    <= next_window_bank_select2;
         gpio_out               <= next_gpio_out;
         gpio_dir               <= next_gpio_dir;
         wr_pend                <= next_wr_pend;
         wr_ofs                 <= next_wr_ofs;
         hreadyout_o            <= 1'b1;   // never inserts wait states
         hresp_o                <= 1'b0;   // always OKAY
         hrdata_o               <= next_hrdata;
         bank_address_lines     <= next_xa;
         addr_hi_o              <= next_addr_hi;
         port_out_o             <= next_port_out;
         port_oe_o              <= next_port_oe;
         st_hit1                <= sel1;
         st_hit2                <= sel2;
      end
   end

endmodule // mwp_top

// ==== hdl/mwp_win_decode.sv ====
`timescale 1ns/100ps
// decodes one window: hit, which bank lines carry the bank, bit 14 swap
module mwp_win_decode
   import mwp_pkg::*;
(
   // upper cpu address bits 15..13
   input  wire logic [2:0]      cpu_top_i,
   // window configuration
   input  wire logic [1:0]      size_i,
   input  wire logic [2:0]      base_i,
   // decode results
   output logic                 hit_o,
   output logic [XA_W-1:0]      bank_use_o,
   output logic                 inv14_o
);

   // base bits below the window size are ignored, except base_i[1] in 32K mode, which picks 4000h
   always_comb begin
      hit_o      = 1'b0;
      bank_use_o = '0;
      inv14_o    = 1'b0;
      case (mwp_size_t'(size_i))
         MWP_SZ_8K: begin
            hit_o      = (cpu_top_i == base_i);
            bank_use_o = 6'h3F;
         end
         MWP_SZ_16K: begin
            hit_o      = (cpu_top_i[2:1] == base_i[2:1]);
            bank_use_o = 6'h3E;
         end
         MWP_SZ_32K: begin
            bank_use_o = 6'h3C;
            if (base_i[2:1] == BASE_SPECIAL_32K) begin
               // 4000h..BFFFh: the window straddles bit 15
               hit_o   = cpu_top_i[2] ^ cpu_top_i[1];
               inv14_o = 1'b1;
            end else begin
               hit_o   = (cpu_top_i[2] == base_i[2]);
            end
         end
         default: begin
            hit_o = 1'b0;
         end
      endcase
   end

endmodule // mwp_win_decode

// ==== pkg/mwp_pkg.sv ====
// shared constants of the memory window paging block
package mwp_pkg;

   // bank address lines cover expansion bits 18..13
   localparam int unsigned XA_W    = 6;
   localparam int unsigned XA_LSB  = 13;
   localparam int unsigned CPU_AW  = 16;
   localparam int unsigned BUS_AW  = 32;
   localparam int unsigned BUS_DW  = 32;

   // register byte offsets on the bus
   localparam logic [7:0] OFS_PIN_ASSIGN = 8'h00;
   localparam logic [7:0] OFS_WIN_SIZE   = 8'h04;
   localparam logic [7:0] OFS_WIN_BASE   = 8'h08;
   localparam logic [7:0] OFS_BANK_SEL1  = 8'h0C;
   localparam logic [7:0] OFS_BANK_SEL2  = 8'h10;
   localparam logic [7:0] OFS_GPIO_OUT   = 8'h14;
   localparam logic [7:0] OFS_GPIO_DIR   = 8'h18;
   localparam logic [7:0] OFS_GPIO_IN    = 8'h1C;
   localparam logic [7:0] OFS_STATUS     = 8'h20;

   // field positions
   localparam int unsigned POS_SIZE1  = 0;   // window 1 size, 2 bits
   localparam int unsigned POS_SIZE2  = 4;   // window 2 size, 2 bits
   localparam int unsigned POS_BASE1  = 1;   // window 1 base, 3 bits
   localparam int unsigned POS_BASE2  = 5;   // window 2 base, 3 bits
   localparam int unsigned POS_BANK   = 1;   // bank select, 6 bits
   localparam int unsigned POS_ST_HIT1 = 0;
   localparam int unsigned POS_ST_HIT2 = 1;
   localparam int unsigned POS_ST_XA   = 8;

   // reset values
   localparam logic [5:0] RST_PIN_ASSIGN = 6'h00;
   localparam logic [1:0] RST_WIN_SIZE   = 2'h0;
   localparam logic [2:0] RST_WIN_BASE   = 3'h0;
   localparam logic [5:0] RST_BANK_SEL   = 6'h00;
   localparam logic [5:0] RST_GPIO       = 6'h00;

   // window size encoding
   typedef enum logic [1:0] {
      MWP_SZ_OFF = 2'h0,
      MWP_SZ_8K  = 2'h1,
      MWP_SZ_16K = 2'h2,
      MWP_SZ_32K = 2'h3
   } mwp_size_t;

   // base field upper bits that place a 32K window at 4000h
   localparam logic [1:0] BASE_SPECIAL_32K = 2'h1;

   // AHB transfer type bit that marks an active transfer
   localparam int unsigned HTRANS_ACT_BIT = 1;

endpackage

// ==== tb/mwp_mem_model.sv ====
`timescale 1ns/100ps
// paged external memory: bank lines and cpu lines form one flat address
module mwp_mem_model (
   // clock
   input  wire logic        clk_i,
   // write strobe and data from the bench cpu
   input  wire logic        we_i,
   input  wire logic [7:0]  d_i,
   // address pins: bank lines 18..16, lines 15..13, cpu 12..0
   input  wire logic [2:0]  xa_up_i,
   input  wire logic [2:0]  a_hi_i,
   input  wire logic [12:0] a_lo_i,
   // registered read data
   output logic      [7:0]  q_o
);
   logic [18:0] phys;
   bit   [7:0]  mem [bit [18:0]];

   // bank lines pick the bank, cpu lines the byte inside it
   assign phys = {xa_up_i, a_hi_i, a_lo_i};

   // unwritten places read zero; a real part would hold anything there
   always @(posedge clk_i) begin
      if (we_i) begin
         mem[phys] = d_i;
      end
      q_o <= mem.exists(phys) ? mem[phys] : 8'h00;
   end
endmodule // mwp_mem_model

// ==== tb/mwp_top_sva.sv ====
`timescale 1ns/100ps
// port-level checks; a shadow of the pin and gpio registers is kept here
module mwp_top_sva
   import mwp_pkg::*;
(
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              sys_rst_i,
   // bus side
   input  wire logic              hsel_i,
   input  wire logic [BUS_AW-1:0] haddr_i,
   input  wire logic [1:0]        htrans_i,
   input  wire logic              hwrite_i,
   input  wire logic [BUS_DW-1:0] hwdata_i,
   input  wire logic              hready_i,
   input  wire logic              hreadyout_o,
   input  wire logic              hresp_o,
   input  wire logic [BUS_DW-1:0] hrdata_o,
   // cpu and pin side
   input  wire logic [CPU_AW-1:0] cpu_addr_i,
   input  wire logic              internal_sel_i,
   input  wire logic [2:0]        addr_hi_o,
   input  wire logic [XA_W-1:0]   port_out_o,
   input  wire logic [XA_W-1:0]   port_oe_o
);
   logic       wr_pend, next_wr_pend, rd_pend, next_rd_pend, take;
   logic [7:0] ofs, next_ofs;
   logic [5:0] sh_pa, sh_dir, sh_gout, next_pa, next_dir, next_gout;
   logic [5:0] gpio_mask;
   logic [2:0] pa_lo, cpu_top;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   // shadow follows the bus, so no design internals are needed
   always_comb begin
      take = hsel_i & htrans_i[HTRANS_ACT_BIT] & hready_i;
      next_wr_pend = take & hwrite_i;
      next_rd_pend = take & ~hwrite_i;
      next_ofs = {haddr_i[7:2], 2'h0};
      next_pa = sh_pa;
      next_dir = sh_dir;
      next_gout = sh_gout;
      if (wr_pend && ofs == OFS_PIN_ASSIGN) next_pa = hwdata_i[5:0];
      if (wr_pend && ofs == OFS_GPIO_DIR) next_dir = hwdata_i[5:0];
      if (wr_pend && ofs == OFS_GPIO_OUT) next_gout = hwdata_i[5:0];
      gpio_mask = sh_dir & ~sh_pa;
      pa_lo = sh_pa[2:0];
      cpu_top = cpu_addr_i[15:13];
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         {wr_pend, rd_pend, ofs} <= '0;
         {sh_pa, sh_dir, sh_gout} <= '0;
      end else begin
         {wr_pend, rd_pend, ofs} <= {next_wr_pend, next_rd_pend, next_ofs};
         {sh_pa, sh_dir, sh_gout} <= {next_pa, next_dir, next_gout};
      end
   end

   a_bus_okay: assert property (hreadyout_o && !hresp_o)
      else $error("bus answer not ready or not okay");
   a_rdata_idle: assert property (!rd_pend |-> hrdata_o == '0)
      else $error("read data outside a read");
   a_read_pins: assert property (
      rd_pend && ofs == OFS_PIN_ASSIGN |-> hrdata_o == {26'h0, sh_pa})
      else $error("pin setting read back wrong");
   a_oe_select: assert property (
      !$past(sys_rst_i) |-> port_oe_o == ($past(sh_pa) | $past(sh_dir)))
      else $error("pin enable wrong");
   a_gpio_drive: assert property (
      !$past(sys_rst_i) |->
      ((port_out_o ^ $past(sh_gout)) & $past(gpio_mask)) == '0)
      else $error("gpio pin value wrong");
   a_addr_pins: assert property (
      !$past(sys_rst_i) |-> ((addr_hi_o ^ port_out_o[2:0]) & $past(pa_lo)) == 0)
      else $error("address line differs from bank line");
   a_addr_plain: assert property (
      !$past(sys_rst_i) |-> ((addr_hi_o ^ $past(cpu_top)) & ~$past(pa_lo)) == 0)
      else $error("unassigned address line wrong");
   a_inside_bypass: assert property (
      !$past(sys_rst_i) && $past(internal_sel_i) |-> addr_hi_o == $past(cpu_top))
      else $error("internal access paged");
   a_miss_upper: assert property (
      !$past(sys_rst_i) && $past(internal_sel_i) |->
      (port_out_o & $past(sh_pa) & 6'h38) == '0)
      else $error("upper bank lines driven on bypass");

   c_read: cover property (rd_pend);
   c_inside: cover property (internal_sel_i);
   c_paged: cover property (sh_pa != '0 && port_oe_o != '0);
endmodule // mwp_top_sva

bind mwp_top mwp_top_sva u_sva (.clk_i, .sys_rst_i, .hsel_i, .haddr_i,
   .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hreadyout_o, .hresp_o,
   .hrdata_o, .cpu_addr_i, .internal_sel_i, .addr_hi_o, .port_out_o,
   .port_oe_o);

// ==== tb/tb_memory_window_paging.sv ====
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin errors++; \
   $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module tb_memory_window_paging;
   import mwp_pkg::*;
   logic        clk_i = 1'b0, sys_rst_i = 1'b1;
   logic        hsel = 1'b0, hwrite = 1'b0, isel = 1'b0, mem_we = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, x;
   logic [1:0]  htrans = '0;
   logic [15:0] cpu_addr = '0;
   logic [5:0]  ext_in = 6'h0A;
   logic [7:0]  mem_d = '0;
   wire         hreadyout, hresp;
   wire  [31:0] hrdata;
   wire  [2:0]  addr_hi;
   wire  [5:0]  port_out, port_oe, port_wire;
   wire  [7:0]  mem_q;
   int          errors = 0, n_tests = 0, cycles = 0;
   logic [5:0]  size_tbl [4] = '{6'h00, 6'h2B, 6'h2A, 6'h28};

   // pin level: module where enabled, outside driver elsewhere
   assign port_wire = (port_out & port_oe) | (ext_in & ~port_oe);

   mwp_top uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
      .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
      .cpu_addr_i(cpu_addr), .internal_sel_i(isel), .addr_hi_o(addr_hi),
      .port_in_i(port_wire), .port_out_o(port_out), .port_oe_o(port_oe));
   mwp_mem_model u_mem (.clk_i(clk_i), .we_i(mem_we), .d_i(mem_d),
      .xa_up_i(port_wire[5:3]), .a_hi_i(addr_hi), .a_lo_i(cpu_addr[12:0]),
      .q_o(mem_q));

   always #20 clk_i = ~clk_i;

   // a hang ends the run with a mismatch
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 4000) begin
         errors++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // one single transfer; no fixed latency is assumed, hready is awaited
   // and only the cycle ceiling above can end a wait
   task automatic bus(input logic wr, input logic [7:0] ofs,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_i);
      hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= {24'h0, ofs};
      do @(posedge clk_i); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
      do @(posedge clk_i); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
      logic [31:0] dummy;
      bus(1'b1, ofs, d, dummy);
   endtask

   // outputs lag the cpu address by one edge; judged mid-cycle
   task automatic probe(input logic [15:0] a, input logic s,
                        input logic [5:0] ep, input logic [2:0] eh);
      @(posedge clk_i);
      cpu_addr <= a; isel <= s;
      @(posedge clk_i);
      @(negedge clk_i);
      `CHK("bank lines", ep, port_out & port_oe)
      `CHK("address lines", eh, addr_hi)
   endtask

   task automatic t_reset();
      `CHK("enable at reset", 6'h00, port_oe)
      wr(8'h24, 32'hFFFF_FFFF);
      for (int o = 0; o <= 36; o += 4) begin
         bus(1'b0, o[7:0], '0, x);
         // the input register shows the outside drive on undriven pins
         `CHK("register at reset", (o == OFS_GPIO_IN) ? 32'(ext_in) : 32'h0, x)
      end
   endtask

   task automatic t_sizes();
      wr(OFS_PIN_ASSIGN, 32'h3F);
      wr(OFS_BANK_SEL1, 32'h2B << POS_BANK);
      for (int s = 0; s < 4; s++) begin
         wr(OFS_WIN_SIZE, s << POS_SIZE1);
         probe(16'h0000, 1'b0, size_tbl[s], size_tbl[s][2:0]);
      end
      wr(OFS_WIN_SIZE, 32'h1);
      probe(16'h2000, 1'b0, 6'h01, 3'h1);
   endtask

   task automatic t_32k();
      wr(OFS_WIN_SIZE, 32'h3);
      wr(OFS_WIN_BASE, 32'h2 << POS_BASE1);
      probe(16'h4000, 1'b0, 6'h28, 3'h0);
      probe(16'hBFFF, 1'b0, 6'h2B, 3'h3);
      probe(16'hC000, 1'b0, 6'h06, 3'h6);
      wr(OFS_WIN_BASE, 32'h7 << POS_BASE1);
      probe(16'hC000, 1'b0, 6'h2A, 3'h2);
      probe(16'h4000, 1'b0, 6'h02, 3'h2);
   endtask

   task automatic t_overlap();
      wr(OFS_WIN_SIZE, 32'h21);
      wr(OFS_WIN_BASE, 32'h02);
      wr(OFS_BANK_SEL1, 32'h15 << POS_BANK);
      wr(OFS_BANK_SEL2, 32'h2A << POS_BANK);
      probe(16'h2000, 1'b0, 6'h15, 3'h5);
      @(posedge clk_i);
      mem_we <= 1'b1; mem_d <= 8'hA5;
      @(posedge clk_i);
      mem_we <= 1'b0;
      probe(16'h0000, 1'b0, 6'h2A, 3'h2);
      // memory read is registered: let it take the new address first
      @(posedge clk_i);
      @(negedge clk_i);
      `CHK("other bank", 1'b1, mem_q !== 8'hA5)
      probe(16'h2000, 1'b0, 6'h15, 3'h5);
      @(posedge clk_i);
      @(negedge clk_i);
      `CHK("same bank", 8'hA5, mem_q)
      probe(16'h2000, 1'b1, 6'h01, 3'h1);
      @(posedge clk_i);
      isel <= 1'b0;
   endtask

   task automatic t_gpio();
      wr(OFS_WIN_SIZE, 32'h1);
      wr(OFS_WIN_BASE, 32'h0);
      wr(OFS_BANK_SEL1, 32'h3F << POS_BANK);
      wr(OFS_PIN_ASSIGN, 32'h05);
      wr(OFS_GPIO_OUT, 32'h10);
      wr(OFS_GPIO_DIR, 32'h30);
      bus(1'b0, OFS_PIN_ASSIGN, '0, x);
      `CHK("pin setting", 32'h05, x)
      probe(16'h0000, 1'b0, 6'h15, 3'h5);
      `CHK("pin enables", 6'h35, port_oe)
      repeat (6) @(posedge clk_i);
      bus(1'b0, OFS_GPIO_IN, '0, x);
      `CHK("gpio input", 32'h1F, x)
   endtask

   initial begin
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      t_reset();
      t_sizes();
      t_32k();
      t_overlap();
      t_gpio();
      report_and_stop();
   end
endmodule // tb_memory_window_paging
